//--- logic/hkpd_top.sv
// Headset key press detector with debounce, flags, raw conversion and AXI4-Lite registers
// What this block does
// - Contact voltage falling below threshold starts the press debounce timer.
// - Glitching restarts the press timer; once settled it runs to completion.
// - Press debounce end sets the key press flag and raises the interrupt.
// - Setting a key press flag clears that key's release flag.
// - Contact returning to bias level starts the release debounce timer.
// - Release debounce expiry sets the release flag and raises the interrupt.
// - Host reading the flag register clears flags and drops the interrupt.
// - Unread flags keep accumulating across successive keys.
// - Timing and flags identical for sleeve or second ring microphone.
// - Clearing enable stops detection at once and clears all key flags.
// - Turning raw mode on keeps pending press and release flags.
// - Raw mode ignores thresholds and reports only through key one flags.
// - Result clears only on raw off, disable or removal, never on read.
// - Software trigger reruns conversion without setting key one press.
// - Result updates per detection or trigger in raw mode only; each raw-mode completion sets done flag.
// - Completed result is nonzero, minimum 01h; 00h means none or cleared.
// - Flag register returns to zero on disable write or removal.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module hkpd_top
  import hkpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic contact_below,
  input wire logic [1:0] key_level,
  input wire logic mic_on_second_ring,
  input wire logic accessory_removed,
  input wire logic conv_link_clk,
  input wire logic conv_link_data,
  output logic key_irq
);
  import hkpd_pkg::*;

  // ----------------------------------------------------------------
  // Types and storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HKPD_IDLE = 2'b00,
    HKPD_PRESS_DB = 2'b01,
    HKPD_HELD = 2'b10,
    HKPD_RELEASE_DB = 2'b11
  } hkpd_state_t;

  hkpd_state_t state;
  logic key_detect_enable;
  logic raw_mode;
  logic [15:0] press_db;
  logic [15:0] release_db;
  logic [23:0] thresh;
  logic [3:0] press_flag;
  logic [3:0] release_flag;
  logic conv_done_flag;
  logic [7:0] result;
  logic [15:0] db_cnt;
  logic [1:0] held_key;
  logic below_s;
  logic removed_s;
  logic link_clk_s;
  logic link_data_s;
  logic link_clk_d;
  logic [1:0] level_s;
  logic ring_s;
  logic conv_busy;
  logic conv_done;
  logic [7:0] conv_code;
  logic conv_start;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The key level code is sampled only while debounced, so per-bit sync is safe
  hkpd_sync u_sync_below (.aclk(aclk), .aresetn(aresetn), .din(contact_below), .dout(below_s));
  hkpd_sync u_sync_rem (.aclk(aclk), .aresetn(aresetn), .din(accessory_removed),
    .dout(removed_s));
  hkpd_sync u_sync_lclk (.aclk(aclk), .aresetn(aresetn), .din(conv_link_clk),
    .dout(link_clk_s));
  hkpd_sync u_sync_ldat (.aclk(aclk), .aresetn(aresetn), .din(conv_link_data),
    .dout(link_data_s));
  hkpd_sync u_sync_lv0 (.aclk(aclk), .aresetn(aresetn), .din(key_level[0]), .dout(level_s[0]));
  hkpd_sync u_sync_lv1 (.aclk(aclk), .aresetn(aresetn), .din(key_level[1]), .dout(level_s[1]));
  hkpd_sync u_sync_ring (.aclk(aclk), .aresetn(aresetn), .din(mic_on_second_ring),
    .dout(ring_s));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic rd_fire;
  logic flag_read;
  logic ctrl_wr;
  logic trigger;
  logic next_enable;
  logic next_raw;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign flag_read = rd_fire && s_axi_araddr[7:2] == OFS_FLAGS[7:2];
  assign ctrl_wr = wr_ok && aw_addr[7:2] == OFS_CTRL[7:2] && w_strb[0];
  assign trigger = ctrl_wr && w_data[CTRL_TRIGGER];
  assign next_enable = ctrl_wr ? w_data[CTRL_ENABLE] : key_detect_enable;
  // Raw mode cannot outlive detection enable
  assign next_raw = next_enable && (ctrl_wr ? w_data[CTRL_RAW] : raw_mode);

  function automatic logic is_mapped(input logic [7:0] a);
    return a[7:2] <= OFS_STATUS[7:2] && a[1:0] == 2'b00;
  endfunction

  // Misaligned or unmapped writes change nothing
  assign wr_ok = wr_fire && is_mapped(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      unique case (is_mapped(s_axi_araddr) ? s_axi_araddr[7:2] : 6'h3f)
        OFS_CTRL[7:2]: s_axi_rdata <= {30'h0, raw_mode, key_detect_enable};
        OFS_PRESS_DB[7:2]: s_axi_rdata <= {16'h0, press_db};
        OFS_RELEASE_DB[7:2]: s_axi_rdata <= {16'h0, release_db};
        OFS_THRESH[7:2]: s_axi_rdata <= {8'h0, thresh};
        OFS_FLAGS[7:2]: s_axi_rdata <= {23'h0, conv_done_flag, release_flag, press_flag};
        OFS_RESULT[7:2]: s_axi_rdata <= {24'h0, result};
        OFS_STATUS[7:2]: s_axi_rdata <= {25'h0, conv_busy, held_key, state, below_s,
          ring_s};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_detect_enable <= 1'b0;
      raw_mode <= 1'b0;
      press_db <= PRESS_DB_RESET;
      release_db <= RELEASE_DB_RESET;
      thresh <= THRESH_RESET;
    end else begin
      key_detect_enable <= next_enable;
      raw_mode <= next_raw;
      if (wr_ok && aw_addr[7:2] == OFS_PRESS_DB[7:2]) begin
        press_db <= w_data[15:0];
      end
      if (wr_ok && aw_addr[7:2] == OFS_RELEASE_DB[7:2]) begin
        release_db <= w_data[15:0];
      end
      if (wr_ok && aw_addr[7:2] == OFS_THRESH[7:2]) begin
        thresh <= w_data[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Debounce state machine
  // ----------------------------------------------------------------
  // Microphone position only steers the analogue front end, so it never enters here
  logic press_done;
  logic release_done;
  logic detect_off;
  logic [1:0] key_sel;
  assign detect_off = !next_enable || removed_s;
  assign press_done = state == HKPD_PRESS_DB && below_s && db_cnt == 16'h0;
  assign release_done = state == HKPD_RELEASE_DB && !below_s && db_cnt == 16'h0;
  assign key_sel = raw_mode ? 2'd0 : level_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= HKPD_IDLE;
      db_cnt <= 16'h0;
      held_key <= 2'd0;
    end else if (detect_off) begin
      state <= HKPD_IDLE;
      db_cnt <= 16'h0;
    end else begin
      unique case (state)
        HKPD_IDLE: begin
          if (below_s) begin
            state <= HKPD_PRESS_DB;
            db_cnt <= press_db;
          end
        end
        HKPD_PRESS_DB: begin
          if (!below_s) begin
            state <= HKPD_IDLE;
          end else if (db_cnt != 16'h0) begin
            db_cnt <= db_cnt - 16'h1;
          end else begin
            state <= HKPD_HELD;
            held_key <= key_sel;
          end
        end
        HKPD_HELD: begin
          if (!below_s) begin
            state <= HKPD_RELEASE_DB;
            db_cnt <= release_db;
          end
        end
        HKPD_RELEASE_DB: begin
          if (below_s) begin
            state <= HKPD_HELD;
          end else if (db_cnt != 16'h0) begin
            db_cnt <= db_cnt - 16'h1;
          end else begin
            state <= HKPD_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Key flags
  // ----------------------------------------------------------------
  // Set wins over the read clear, so an event in the read cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      press_flag <= 4'h0;
      release_flag <= 4'h0;
    end else if (detect_off) begin
      press_flag <= 4'h0;
      release_flag <= 4'h0;
    end else begin
      for (int k = 0; k < KEYS; k++) begin
        if (press_done && key_sel == 2'(k)) begin
          press_flag[k] <= 1'b1;
          release_flag[k] <= 1'b0;
        end else if (release_done && held_key == 2'(k)) begin
          release_flag[k] <= 1'b1;
        end else if (flag_read) begin
          release_flag[k] <= 1'b0;
        end
        if (flag_read && !(press_done && key_sel == 2'(k))) begin
          press_flag[k] <= 1'b0;
        end
      end
    end
  end

  assign key_irq = (|press_flag) || (|release_flag) || conv_done_flag;

  // ----------------------------------------------------------------
  // Conversion result
  // ----------------------------------------------------------------
  // Conversions follow a detected press while enabled, or a software trigger in raw mode
  assign conv_start = !detect_off && (press_done || (trigger && next_raw));

  hkpd_conv u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start),
    .link_clk_rise(link_clk_s && !link_clk_d),
    .link_data(link_data_s),
    .busy(conv_busy),
    .done(conv_done),
    .code(conv_code)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 8'h00;
      conv_done_flag <= 1'b0;
    end else if (!next_raw || removed_s) begin
      result <= 8'h00;
      conv_done_flag <= 1'b0;
    end else if (conv_done) begin
      result <= conv_code;
      conv_done_flag <= 1'b1;
    end else if (flag_read) begin
      conv_done_flag <= 1'b0;
    end
  end
endmodule

//--- logic/hkpd_pkg.sv
// Package of register map, field positions and timing counts for the key press detector
package hkpd_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned KEYS = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESS_DB = 8'h04;
  localparam logic [7:0] OFS_RELEASE_DB = 8'h08;
  localparam logic [7:0] OFS_THRESH = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Control field positions
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_RAW = 1;
  localparam int unsigned CTRL_TRIGGER = 2;
  localparam int unsigned CTRL_REMOVAL = 3;
  // Flag register layout
  localparam int unsigned FLAG_PRESS_LSB = 0;
  localparam int unsigned FLAG_RELEASE_LSB = 4;
  localparam int unsigned FLAG_CONV_DONE = 8;
  // Reset values and minimum completed result
  localparam logic [15:0] PRESS_DB_RESET = 16'h0100;
  localparam logic [15:0] RELEASE_DB_RESET = 16'h0100;
  localparam logic [23:0] THRESH_RESET = 24'h604020;
  localparam logic [7:0] RESULT_MIN = 8'h01;
  // Conversion sample settle time in ns, and its cycle count
  localparam int unsigned CONV_TIME_NS = 200;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

//--- logic/hkpd_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/100ps
module hkpd_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], din};
    end
  end

  // Only stages two and three are compared, never the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      dout <= stage[2];
    end
  end
endmodule

//--- logic/hkpd_conv.sv
// Serial conversion capture of the contact level code, clocked by the link strobe
`timescale 1ns/100ps
module hkpd_conv
  import hkpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic link_clk_rise,
  input wire logic link_data,
  output logic busy,
  output logic done,
  output logic [7:0] code
);
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] settle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      settle <= 8'h00;
      code <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        bit_cnt <= 3'h0;
        settle <= 8'(CONV_CYCLES);
      end else if (busy && settle != 8'h00) begin
        settle <= settle - 8'h01;
      end else if (busy && link_clk_rise) begin
        shift <= {shift[6:0], link_data};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          busy <= 1'b0;
          done <= 1'b1;
          // A finished result is never zero
          code <= ({shift[6:0], link_data} == 8'h00) ? RESULT_MIN
                                                     : {shift[6:0], link_data};
        end
      end
    end
  end
endmodule

//--- bench/hkpd_monitor.sv
// Checker for the key press detector: bus handshakes and flag clearing
`timescale 1ns/100ps
module hkpd_monitor
  import hkpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic contact_below,
  input wire logic accessory_removed,
  input wire logic key_irq
);
  logic last_below;
  logic [8:0] calm;
  logic ar_go;
  logic aw_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Quiet contact: no debounce can still fire
  // ----------------------------------------
  always_ff @(posedge aclk) last_below <= contact_below;
  always_ff @(posedge aclk) begin
    if (!aresetn || contact_below != last_below) begin
      calm <= 9'h000;
    end else if (calm != 9'h1ff) begin
      calm <= calm + 9'h001;
    end
  end
  property p_wr_answer; aw_go |-> ##2 s_axi_bvalid; endproperty
  property p_rd_answer; ar_go |=> s_axi_rvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_unmapped;
    ar_go && s_axi_araddr > OFS_STATUS |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_disable_clear;
    aw_go && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0] && !s_axi_wdata[CTRL_ENABLE]
      |-> ##2 !key_irq [*3];
  endproperty
  property p_removal_clear; accessory_removed [*6] |-> !key_irq; endproperty
  property p_read_clear;
    ar_go && s_axi_araddr == OFS_FLAGS && calm > 9'h12c |-> ##[1:3] !key_irq;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_disable_clear: assert property (p_disable_clear)
    else $error("interrupt stays after detection disabled");
  a_removal_clear: assert property (p_removal_clear)
    else $error("interrupt stays during removal");
  a_read_clear: assert property (p_read_clear)
    else $error("flag read did not drop interrupt");
  c_press: cover property ($rose(key_irq));
  c_removal: cover property (accessory_removed ##1 !key_irq);
  c_unmapped: cover property (ar_go && s_axi_araddr > OFS_STATUS);
endmodule
bind hkpd_top hkpd_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .contact_below(contact_below),
  .accessory_removed(accessory_removed), .key_irq(key_irq)
);

//--- bench/hkpd_headset.sv
// Headset front end model: contact level, key index and conversion link
`timescale 1ns/100ps
module hkpd_headset (
  output logic contact_below,
  output logic [1:0] key_level,
  output logic link_clk,
  output logic link_data
);
  initial begin
    contact_below = 1'b0;
    key_level = 2'h0;
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // Link clock stands still outside frames, 160 ns period inside
  task automatic frame(input logic [7:0] code);
    for (int b = 7; b >= 0; b--) begin
      link_data <= code[b];
      #80 link_clk <= 1'b1;
      #80 link_clk <= 1'b0;
    end
    // Released line must not keep showing the last bit
    link_data <= ~link_data;
  endtask
  // Three bounces before settling, then a conversion frame
  task automatic press(input logic [1:0] k, input logic [7:0] code, input logic rel);
    key_level <= k;
    repeat (3) begin
      contact_below <= 1'b1;
      #100 contact_below <= 1'b0;
      #100;
    end
    contact_below <= 1'b1;
    #1200 frame(code);
    #200 contact_below <= !rel;
    // Lets a release debounce finish before any next press
    #400;
  endtask
  task automatic let_go;
    contact_below <= 1'b0;
  endtask
endmodule

//--- bench/test_headset_key_press_detector.sv
// Testbench for the key press detector
`timescale 1ns/100ps
module test_headset_key_press_detector;
  import hkpd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ring = 1'b0, removed = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, below, lclk, ldata;
  logic [1:0] bresp, rresp, klev, r;
  logic [31:0] rdata, rv;
  int n_mismatch = 0;
  int tests_run = 0;
  always #10 aclk = ~aclk;
  hkpd_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .contact_below(below), .key_level(klev),
    .mic_on_second_ring(ring), .accessory_removed(removed), .conv_link_clk(lclk),
    .conv_link_data(ldata), .key_irq(irq));
  hkpd_headset i_hs (.contact_below(below), .key_level(klev), .link_clk(lclk),
    .link_data(ldata));
  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tmo(input int n);
    if (n >= 400) begin
      n_mismatch++;
      $display("[FAIL] handshake timeout");
      wrap_up();
    end
  endtask
  // Ready is sampled at the falling edge, so the decision lands on the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw, b;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 400 && !b; n++) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      b = bvalid;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'b0;
    tmo(n);
    chk("write response", {30'h0, bresp}, {30'h0, AXI_OKAY});
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic pa, ta, b;
    int n;
    pa = 1'b1;
    b = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 400 && !b; n++) begin
      @(negedge aclk);
      ta = pa && arready;
      b = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      pa = pa && !ta;
      arvalid <= pa;
    end
    rready <= 1'b0;
    tmo(n);
  endtask
  // Flag reads wait until every debounce has settled
  task rf(input logic [7:0] a, input logic [31:0] e);
    if (a == OFS_FLAGS) repeat (320) @(posedge aclk);
    rd(a, rv, r);
    chk($sformatf("register %h", a), rv, e);
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    $display("[FAIL] run timeout");
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rf(OFS_PRESS_DB, {16'h0, PRESS_DB_RESET});
    rf(OFS_CTRL, 32'h0);
    rf(OFS_FLAGS, 32'h0);
    rd(8'h20, rv, r);
    chk("unmapped response", {30'h0, r}, {30'h0, AXI_SLVERR});
    wr(OFS_PRESS_DB, 32'h8);
    wr(OFS_RELEASE_DB, 32'h8);
    wr(OFS_CTRL, 32'h1);
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      ring <= i[0];
      fork
        i_hs.press(2'(2 + i), 8'h33, 1'b1);
        begin
          #560 chk("irq while bouncing", {31'h0, irq}, 32'h0);
        end
      join
      rd(OFS_STATUS, rv, r);
      chk("ring status", {31'h0, rv[0]}, {31'h0, ring});
      rf(OFS_FLAGS, 32'h11 << (2 + i));
      rf(OFS_FLAGS, 32'h0);
    end
    $display("single press test done");
    i_hs.press(2'h0, 8'h33, 1'b1);
    i_hs.press(2'h1, 8'h33, 1'b1);
    i_hs.press(2'h0, 8'h33, 1'b0);
    rf(OFS_FLAGS, 32'h23);
    i_hs.let_go();
    rf(OFS_FLAGS, 32'h10);
    $display("multiple press test done");
    i_hs.press(2'h3, 8'h33, 1'b0);
    wr(OFS_CTRL, 32'h0);
    chk("irq after disable", {31'h0, irq}, 32'h0);
    rf(OFS_FLAGS, 32'h0);
    i_hs.let_go();
    wr(OFS_CTRL, 32'h1);
    i_hs.press(2'h1, 8'h33, 1'b0);
    @(posedge aclk);
    removed <= 1'b1;
    i_hs.let_go();
    repeat (10) @(posedge aclk);
    chk("irq after removal", {31'h0, irq}, 32'h0);
    removed <= 1'b0;
    rf(OFS_FLAGS, 32'h0);
    $display("disable and removal test done");
    i_hs.press(2'h3, 8'h33, 1'b1);
    wr(OFS_CTRL, 32'h3);
    i_hs.press(2'h2, 8'h00, 1'b1);
    rf(OFS_FLAGS, 32'h199);
    rf(OFS_RESULT, {24'h0, RESULT_MIN});
    rf(OFS_RESULT, {24'h0, RESULT_MIN});
    wr(OFS_CTRL, 32'h7);
    repeat (15) @(posedge aclk);
    i_hs.frame(8'h5a);
    rf(OFS_FLAGS, 32'h100);
    rf(OFS_RESULT, 32'h5a);
    wr(OFS_CTRL, 32'h1);
    rf(OFS_RESULT, 32'h0);
    $display("raw conversion test done");
    wrap_up();
  end
endmodule
